/* File: bench/erp_ctl_monitor.sv */
module erp_ctl_monitor
   import erp_pkg::*;
(
   input wire logic                       i_clk,
   input wire logic                       i_rstn,
   input wire logic [erp_pkg::ADDR_W-1:0] i_addr,
   input wire logic [erp_pkg::DATA_W-1:0] i_wdata,
   input wire logic                       i_wr,
   input wire logic                       i_external_codec_select,
   input wire logic                       o_irq_outputs,
   input wire logic                       o_irq_ready_line,
   input wire logic                       o_modem_powerdown_out_n,
   input wire erp_pkg::erp_power_s        o_power,
   input wire logic                       o_eeprom_reload,
   input wire logic                       o_bus_mode,
   input wire logic                       o_irq
);
   logic [2:0] up_cnt_reg;
   logic [2:0] up_cnt_next;
   // The strap is taken a few clocks after release, so stability is only checked later.
   always_comb up_cnt_next = (up_cnt_reg == 3'h7) ? up_cnt_reg : up_cnt_reg + 3'h1;
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) up_cnt_reg <= 3'h0;
      else up_cnt_reg <= up_cnt_next;
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   ////////////////////////////////////////////////////////////////////////////
   sequence wr_at(logic [3:0] a);
      i_wr && i_addr == a;
   endsequence
   function_soft_reset_bit_low_a: assert property (wr_at(OFF_OPTION) ##0 i_wdata[7] |=> ##[0:2] !o_irq_ready_line)
      else $error("ready line not lowered by soft reset");
   function_soft_reset_bit_reload_a: assert property (wr_at(OFF_OPTION) ##0 i_wdata[7] |=> ##[0:3] o_eeprom_reload)
      else $error("soft reset did not start a reload");
   function_soft_reset_bit_release_a: assert property (wr_at(OFF_OPTION) ##0 (!i_wdata[7] && !o_irq_ready_line)
      |=> ##[0:2] o_irq_ready_line) else $error("ready line not raised after soft reset");
   bus_mode_kept_a: assert property (up_cnt_reg == 3'h7 |-> $stable(o_bus_mode))
      else $error("bus mode changed without hard reset");
   mac_no_reload_a: assert property (wr_at(OFF_RECV) ##0 (i_wdata[15] && !o_eeprom_reload)
      |=> (!o_eeprom_reload) [*3]) else $error("MAC reset started a reload");
   pin_ignored_a: assert property ((!i_external_codec_select) [*4] |-> o_modem_powerdown_out_n)
      else $error("power-down pin honoured without codec select");
   modem_all_down_a: assert property (!o_modem_powerdown_out_n |-> ##[0:1] o_power.all_down)
      else $error("modem power-down without full power-down");
   legacy_powerdown_bit_bit_a: assert property (wr_at(OFF_CONTROL) ##0 i_wdata[0]
      |=> ##[0:2] (o_power.tx_down && o_power.rx_down && o_power.link_down))
      else $error("power-down bit did not stop tx rx link");
   wake_only_a: assert property (wr_at(OFF_CONTROL) ##0 (i_wdata[1:0] == 2'h2
      && o_modem_powerdown_out_n) |=> ##[0:2] (o_power.tx_down && !o_power.rx_down))
      else $error("wake enable alone not tx only");
   src_off_a: assert property (wr_at(OFF_SRC_EN) ##0 i_wdata == 16'h0 |=> ##[0:2] !o_irq_outputs)
      else $error("interrupt without enabled source");
   irq_masked_a: assert property (wr_at(OFF_EVT_MSK) ##0 i_wdata == 16'h0 |=> ##[0:2] !o_irq)
      else $error("interrupt while all events masked");
endmodule : erp_ctl_monitor
bind erp_ctl erp_ctl_monitor mon_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .i_external_codec_select(i_external_codec_select),
   .o_irq_outputs(o_irq_outputs), .o_irq_ready_line(o_irq_ready_line),
   .o_modem_powerdown_out_n(o_modem_powerdown_out_n), .o_power(o_power),
   .o_eeprom_reload(o_eeprom_reload), .o_bus_mode(o_bus_mode), .o_irq(o_irq));

/* File: bench/erp_host.sv */
module erp_host
   import erp_pkg::*;
(
   input  wire logic                       i_clk,
   output logic      [erp_pkg::ADDR_W-1:0] o_addr,
   output logic      [erp_pkg::DATA_W-1:0] o_wdata,
   output logic                            o_wr,
   output logic                            o_rd,
   input  wire logic [erp_pkg::DATA_W-1:0] i_rdata
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      o_addr = '0;
      o_wdata = '0;
      o_wr = 1'b0;
      o_rd = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Released lines are inverted so a stale value can never pass for a live one.
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
      @(posedge i_clk);
      o_addr <= a;
      o_wdata <= (a == OFF_STATUS) ? (v & ~(16'h1 << ST_PDOWN_BIT)) : v;
      o_wr <= 1'b1;
      @(posedge i_clk);
      o_wr <= 1'b0;
      o_addr <= ~a;
      o_wdata <= ~v;
   endtask : wr
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
      @(posedge i_clk);
      o_addr <= a;
      o_rd <= 1'b1;
      @(posedge i_clk);
      o_rd <= 1'b0;
      o_addr <= ~a;
      #1;
      v = i_rdata;
   endtask : rd
endmodule : erp_host

/* File: bench/tb_erp_ctl.sv */
module tb_erp_ctl import erp_pkg::*; ;
   timeunit 1ns;
   timeprecision 100ps;
   logic i_clk = 1'b0, i_rstn = 1'b0, pin = 1'b0, codec = 1'b0, strap = 1'b1, edone = 1'b0;
   logic [SRC_W-1:0] src = '0;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata, d;
   logic wr, rd, irq_o, rdy, modem_n, reload, macr, busm, irq;
   erp_power_s pwr;
   int error_cnt = 0, checked = 0, cyc = 0;
   logic [15:0] ctl [5] = '{16'h0, 16'h2, 16'h3, 16'h1, 16'h0};
   logic [3:0] pexp [5] = '{4'h0, 4'h8, 4'hE, 4'hE, 4'h0};
   logic [3:0] keep_a [3] = '{OFF_ADDR, OFF_CONFIG, OFF_BASE};
   logic [15:0] keep_v [3] = '{16'h1234, 16'h5A5A, 16'h0320};
   always #5 i_clk = ~i_clk;
   erp_ctl dut_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
      .i_rd(rd), .o_rdata(rdata), .i_src_set(src), .i_powerdown_input_pin(pin),
      .i_external_codec_select(codec), .i_bus_mode_strap(strap), .i_eeprom_done(edone),
      .o_irq_outputs(irq_o), .o_irq_ready_line(rdy), .o_modem_powerdown_out_n(modem_n),
      .o_power(pwr), .o_eeprom_reload(reload), .o_mac_reset(macr), .o_bus_mode(busm),
      .o_irq(irq));
   erp_host host_u (.i_clk(i_clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd),
      .i_rdata(rdata));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
         error_cnt++;
      end
   endtask : chk
   // Four edges cover the two sync flops plus the output flop of every path.
   task automatic nap();
      repeat (4) @(posedge i_clk);
      #1;
   endtask : nap
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : close_out
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 4000) begin
         error_cnt++;
         close_out();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge i_clk);
      i_rstn <= 1'b1;
      nap();
      chk("bus_mode", 16'h1, busm);
      chk("reload", 16'h1, reload);
      host_u.rd(4'hC, d);
      chk("unmapped", 16'h0, d);
      @(posedge i_clk) edone <= 1'b1;
      host_u.wr(OFF_SRC_EN, 16'h0008);
      @(posedge i_clk) src <= 8'h28;
      @(posedge i_clk) src <= 8'h00;
      nap();
      chk("irq_outputs", 16'h1, irq_o);
      host_u.rd(OFF_STATUS, d);
      chk("intr_bit", 16'h1, d[ST_INTR_BIT]);
      host_u.wr(OFF_SRC_ST, 16'h0008);
      nap();
      chk("irq_cleared", 16'h0, irq_o);
      host_u.rd(OFF_SRC_ST, d);
      chk("src_status", 16'h0020, d);
      host_u.wr(OFF_SRC_EN, 16'h0020);
      nap();
      chk("irq_second", 16'h1, irq_o);
      host_u.wr(OFF_SRC_EN, 16'h0000);
      host_u.wr(OFF_OPTION, 16'h0001);
      for (int i = 0; i < 5; i++) begin
         host_u.wr(OFF_CONTROL, ctl[i]);
         nap();
         chk("power", {12'h0, pexp[i]}, {12'h0, pwr});
      end
      host_u.wr(OFF_EVT_ST, 16'h000F);
      host_u.wr(OFF_EVT_MSK, 16'h0000);
      host_u.wr(OFF_CONTROL, 16'h0001);
      nap();
      chk("irq_masked", 16'h0, irq);
      host_u.rd(OFF_EVT_ST, d);
      chk("evt_pdn", 16'h1, d[EVT_PDN]);
      host_u.wr(OFF_EVT_MSK, 16'h0004);
      nap();
      chk("irq_raised", 16'h1, irq);
      host_u.wr(OFF_EVT_ST, 16'h0004);
      nap();
      chk("irq_clear", 16'h0, irq);
      host_u.wr(OFF_CONTROL, 16'h0002);
      @(posedge i_clk) pin <= 1'b1;
      nap();
      chk("pin_no_codec", 16'h1, modem_n);
      @(posedge i_clk) codec <= 1'b1;
      nap();
      chk("modem_out", 16'h0, modem_n);
      chk("all_down", 16'h1, pwr.all_down);
      @(posedge i_clk) pin <= 1'b0;
      nap();
      chk("pin_wake", 16'h8, {12'h0, pwr});
      host_u.rd(OFF_CONTROL, d);
      chk("ctl_kept", 16'h0002, d);
      host_u.wr(OFF_SRC_EN, 16'h0008);
      @(posedge i_clk) edone <= 1'b0;
      host_u.wr(OFF_OPTION, 16'h0080);
      nap();
      chk("ready_low", 16'h0, rdy);
      chk("function_soft_reset_bit_reload", 16'h1, reload);
      host_u.rd(OFF_SRC_EN, d);
      chk("held_en", 16'h0, d);
      host_u.wr(OFF_OPTION, 16'h0000);
      nap();
      chk("ready_high", 16'h1, rdy);
      chk("mode_kept", 16'h1, busm);
      @(posedge i_clk) edone <= 1'b1;
      host_u.wr(OFF_CONTROL, 16'h0002);
      for (int i = 0; i < 3; i++) host_u.wr(keep_a[i], keep_v[i]);
      host_u.wr(OFF_RECV, 16'h8000);
      nap();
      chk("mac_reset", 16'h1, macr);
      chk("mac_reload", 16'h0, reload);
      host_u.wr(OFF_RECV, 16'h0000);
      for (int i = 0; i < 3; i++) begin
         host_u.rd(keep_a[i], d);
         chk("mac_kept", keep_v[i], d);
      end
      host_u.rd(OFF_CONTROL, d);
      chk("mac_ctl", 16'h0, d);
      @(posedge i_clk) strap <= 1'b0;
      i_rstn <= 1'b0;
      edone <= 1'b0;
      repeat (2) @(posedge i_clk);
      i_rstn <= 1'b1;
      nap();
      chk("resample", 16'h0, busm);
      chk("hard_reload", 16'h1, reload);
      host_u.rd(OFF_BASE, d);
      chk("base_rst", BASE_RST, d);
      close_out();
   end
endmodule : tb_erp_ctl

/* File: rtl/erp_ctl.sv */
// Local design decisions: the register offsets and the address-and-strobe port.
module erp_ctl
   import erp_pkg::*;
(
   input  wire logic                        i_clk,
   input  wire logic                        i_rstn,
   input  wire logic [erp_pkg::ADDR_W-1:0]  i_addr,
   input  wire logic [erp_pkg::DATA_W-1:0]  i_wdata,
   input  wire logic                        i_wr,
   input  wire logic                        i_rd,
   output logic      [erp_pkg::DATA_W-1:0]  o_rdata,
   input  wire logic [erp_pkg::SRC_W-1:0]   i_src_set,
   input  wire logic                        i_powerdown_input_pin,
   input  wire logic                        i_external_codec_select,
   input  wire logic                        i_bus_mode_strap,
   input  wire logic                        i_eeprom_done,
   output logic                             o_irq_outputs,
   output logic                             o_irq_ready_line,
   output logic                             o_modem_powerdown_out_n,
   output erp_pkg::erp_power_s              o_power,
   output logic                             o_eeprom_reload,
   output logic                             o_mac_reset,
   output logic                             o_bus_mode,
   output logic                             o_irq
);
   import erp_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; the first stage feeds only the second.
   // Reset clears both stages, so every pin reads low for two clocks after release.
   // The bus mode strap is a pin too, so its capture must wait for both stages.
   logic [3:0] sync1_reg;
   logic [3:0] sync2_reg;
   logic       pin_pd;
   logic       codec_sel;
   logic       eep_done;
   logic       strap_sync;

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         sync1_reg <= 4'h0;
         sync2_reg <= 4'h0;
      end else begin
         sync1_reg <= {i_bus_mode_strap, i_eeprom_done, i_external_codec_select,
                       i_powerdown_input_pin};
         sync2_reg <= sync1_reg;
      end
   end

   assign pin_pd     = sync2_reg[0];
   assign codec_sel  = sync2_reg[1];
   assign eep_done   = sync2_reg[2];
   assign strap_sync = sync2_reg[3];

   ////////////////////////////////////////////////////////////////////////////
   // Register state; each group keeps its next value beside it.
   logic                  wr_sel;
   logic [DATA_W-1:0]     option_reg, option_next;
   logic [DATA_W-1:0]     status_reg, status_next;
   logic [DATA_W-1:0]     control_reg, control_next;
   logic [DATA_W-1:0]     recv_reg, recv_next;
   logic [SRC_W-1:0]      src_st_reg, src_st_next;
   logic [SRC_W-1:0]      src_en_reg, src_en_next;
   logic [DATA_W-1:0]     addr_reg, addr_next;
   logic [DATA_W-1:0]     config_reg, config_next;
   logic [DATA_W-1:0]     base_reg, base_next;
   logic [EVT_W-1:0]      evt_st_reg, evt_st_next;
   logic [EVT_W-1:0]      evt_msk_reg, evt_msk_next;
   logic [EVT_W-1:0]      evt_set;
   logic [1:0]            strap_cnt_reg, strap_cnt_next;
   logic                  bus_mode_reg, bus_mode_next;
   logic                  reload_reg, reload_next;
   logic                  pin_active;
   logic                  func_rst;
   logic                  mac_rst;
   logic                  merged_irq;
   logic [DATA_W-1:0]     rdata_next;
   erp_pstate_e           pstate_reg, pstate_next;
   erp_power_s            power_next;

   // Address decode shared by the write path and the soft reset write-through.
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] off);
      hit = (a == off);
   endfunction : hit

   assign wr_sel     = i_wr;
   assign func_rst   = option_reg[OPT_SOFT_RST_BIT];                  // [R5]
   assign mac_rst    = recv_reg[RECV_SOFT_RST_BIT];                   // [R8]
   // Only the per-source enables gate the merged interrupt; there is no global enable.
   assign merged_irq = |(src_st_reg & src_en_reg);                   // [R1] [R3]
   // The power-down pin is ignored unless the external codec is selected.
   assign pin_active = pin_pd && codec_sel;                          // [R9]

   ////////////////////////////////////////////////////////////////////////////
   // Power state; the function enable bit never enters this decode.
   // The pin wins over both control bits, and the power-down bit wins over wake enable.
   // Decoding from the next state lets the output flop follow the bits with no extra lag.
   always_comb begin
      if (pin_active) begin
         pstate_next = PS_ALL_DOWN;                                  // [R11] [R15]
      end else if (control_reg[CTL_PDOWN_BIT]) begin
         pstate_next = PS_TRL_DOWN;                                  // [R10] [R13]
      end else if (control_reg[CTL_WAKE_BIT]) begin
         pstate_next = PS_TX_DOWN;                                   // [R11]
      end else begin
         pstate_next = PS_AWAKE;                                     // [R12] [R13]
      end
      power_next = '0;
      case (pstate_next)
         PS_AWAKE:    power_next = '0;
         PS_TX_DOWN:  power_next = '{tx_down: 1'b1, default: 1'b0};
         PS_TRL_DOWN: power_next = '{all_down: 1'b0, default: 1'b1};
         PS_ALL_DOWN: power_next = '1;
         // An unknown state powers everything down as the safe choice.
         default:     power_next = '1;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register file next-state logic. Writes are applied first and the resets then
   // override them, so a soft reset in progress cannot be undone by a stray write.
   // Sources arriving on i_src_set are sticky until written back as ones or cleared by a function or MAC soft reset.
   always_comb begin
      option_next        = option_reg;
      status_next        = status_reg;
      control_next       = control_reg;
      recv_next          = recv_reg;
      src_st_next        = src_st_reg | i_src_set;
      src_en_next        = src_en_reg;
      addr_next          = addr_reg;
      config_next        = config_reg;
      base_next          = base_reg;
      evt_msk_next       = evt_msk_reg;
      strap_cnt_next     = (strap_cnt_reg != 2'h0) ? strap_cnt_reg - 2'h1 : 2'h0;
      bus_mode_next      = bus_mode_reg;
      reload_next        = reload_reg;
      evt_set            = '0;

      // Bus mode is caught once the synchronised strap has settled after hard reset.
      // Only the hard reset reloads this counter, so soft resets never resample the mode.
      if (strap_cnt_reg == 2'h1) begin
         bus_mode_next = strap_sync;                                 // [R4]
      end
      // A finished EEPROM load ends the pending reload unless a soft reset restarts it.
      if (eep_done) begin
         reload_next = 1'b0;
      end

      if (wr_sel) begin
         if (hit(i_addr, OFF_OPTION)) begin
            option_next = i_wdata;                                   // [R2]
         end
         if (hit(i_addr, OFF_STATUS)) begin
            // Power-down bit is kept writable but feeds no logic.
            // Software must keep it at zero in this bus mode.
            status_next[ST_PDOWN_BIT] = i_wdata[ST_PDOWN_BIT];       // [R14]
         end
         if (hit(i_addr, OFF_CONTROL)) begin
            control_next = i_wdata;
         end
         if (hit(i_addr, OFF_RECV)) begin
            recv_next = i_wdata;
         end
         if (hit(i_addr, OFF_SRC_ST)) begin
            // Write one to clear; a source arriving now still sets.
            src_st_next = (src_st_reg & ~i_wdata[SRC_W-1:0]) | i_src_set;  // [R2]
         end
         if (hit(i_addr, OFF_SRC_EN)) begin
            src_en_next = i_wdata[SRC_W-1:0];
         end
         if (hit(i_addr, OFF_ADDR)) begin
            addr_next = i_wdata;
         end
         if (hit(i_addr, OFF_CONFIG)) begin
            config_next = i_wdata;
         end
         if (hit(i_addr, OFF_BASE)) begin
            base_next = i_wdata;
         end
         if (hit(i_addr, OFF_EVT_MSK)) begin
            evt_msk_next = i_wdata[EVT_W-1:0];
         end
      end

      // Function soft reset returns everything below it to its reset value except its own bit.
      // Bus mode and the event registers lie outside its reach.
      if (func_rst) begin                                            // [R5]
         option_next  = '0;
         option_next[OPT_SOFT_RST_BIT] = (wr_sel && hit(i_addr, OFF_OPTION)) ?
                                         i_wdata[OPT_SOFT_RST_BIT] : 1'b1;
         status_next  = '0;
         control_next = '0;
         recv_next    = '0;
         src_st_next  = '0;
         src_en_next  = '0;
         addr_next    = ADDR_RST;
         config_next  = CONFIG_RST;
         base_next    = BASE_RST;
         reload_next  = 1'b1;                                        // [R5]
      end else if (mac_rst) begin
         // MAC reset keeps address, config and base; no reload.
         control_next = '0;                                          // [R8]
         src_st_next  = '0;
         src_en_next  = '0;
         recv_next[RECV_SOFT_RST_BIT] = (wr_sel && hit(i_addr, OFF_RECV)) ?
                                        i_wdata[RECV_SOFT_RST_BIT] : 1'b1;
      end

      status_next[ST_INTR_BIT] = merged_irq;                         // [R2]

      // Event status bits are sticky; a new event in the clear cycle wins over the clear.
      // Power events fire on the edges of the awake state, not on every decode change.
      evt_set[EVT_IRQ]    = merged_irq;
      evt_set[EVT_PDN]    = (pstate_next != PS_AWAKE) && (pstate_reg == PS_AWAKE);
      evt_set[EVT_WAKE]   = (pstate_next == PS_AWAKE) && (pstate_reg != PS_AWAKE);
      evt_set[EVT_RELOAD] = reload_reg && eep_done;
      evt_st_next = evt_st_reg;
      if (wr_sel && hit(i_addr, OFF_EVT_ST)) begin
         evt_st_next = evt_st_reg & ~i_wdata[EVT_W-1:0];
      end
      evt_st_next = evt_st_next | evt_set;

      // Read data is registered and returns to zero one cycle after the strobe.
      rdata_next = '0;
      if (i_rd) begin
         case (i_addr)
            OFF_OPTION:  rdata_next = option_reg;
            OFF_STATUS:  rdata_next = status_reg;
            OFF_CONTROL: rdata_next = control_reg;
            OFF_RECV:    rdata_next = recv_reg;
            OFF_SRC_ST:  rdata_next = {{(DATA_W-SRC_W){1'b0}}, src_st_reg};
            OFF_SRC_EN:  rdata_next = {{(DATA_W-SRC_W){1'b0}}, src_en_reg};
            OFF_ADDR:    rdata_next = addr_reg;
            OFF_CONFIG:  rdata_next = config_reg;
            OFF_BASE:    rdata_next = base_reg;
            OFF_EVT_ST:  rdata_next = {{(DATA_W-EVT_W){1'b0}}, evt_st_reg};
            OFF_EVT_MSK: rdata_next = {{(DATA_W-EVT_W){1'b0}}, evt_msk_reg};
            OFF_STATE:   rdata_next = {11'h000, bus_mode_reg, reload_reg,
                                       power_next.tx_down, power_next.rx_down,
                                       power_next.all_down};
            default:     rdata_next = '0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // All state except the pin synchronisers, and every top-level output, come straight from these flops.
   // The hard reset returns every register here to its power-on value.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin                                             // [R4]
         option_reg        <= '0;
         status_reg        <= '0;
         control_reg       <= '0;
         recv_reg          <= '0;
         src_st_reg        <= '0;
         src_en_reg        <= '0;
         addr_reg          <= ADDR_RST;
         config_reg        <= CONFIG_RST;
         base_reg          <= BASE_RST;
         evt_st_reg        <= '0;
         evt_msk_reg       <= '0;
         strap_cnt_reg     <= STRAP_WAIT;
         bus_mode_reg      <= 1'b0;
         reload_reg        <= 1'b1;
         pstate_reg        <= PS_AWAKE;
         o_rdata           <= '0;
         o_irq_outputs     <= 1'b0;
         o_irq_ready_line  <= 1'b1;
         o_modem_powerdown_out_n <= 1'b1;
         o_power           <= '0;
         o_eeprom_reload   <= 1'b1;
         o_mac_reset       <= 1'b0;
         o_bus_mode        <= 1'b0;
         o_irq             <= 1'b0;
      end else begin
         option_reg        <= option_next;
         status_reg        <= status_next;
         control_reg       <= control_next;
         recv_reg          <= recv_next;
         src_st_reg        <= src_st_next;
         src_en_reg        <= src_en_next;
         addr_reg          <= addr_next;
         config_reg        <= config_next;
         base_reg          <= base_next;
         evt_st_reg        <= evt_st_next;
         evt_msk_reg       <= evt_msk_next;
         strap_cnt_reg     <= strap_cnt_next;
         bus_mode_reg      <= bus_mode_next;
         reload_reg        <= reload_next;
         pstate_reg        <= pstate_next;
         o_rdata           <= rdata_next;
         o_irq_outputs     <= merged_irq;                            // [R1]
         // The ready line follows the next soft reset bit, so it drops with the write itself.
         o_irq_ready_line  <= !option_next[OPT_SOFT_RST_BIT];        // [R6] [R7]
         o_modem_powerdown_out_n <= !pin_active;                     // [R11]
         o_power           <= power_next;
         o_eeprom_reload   <= reload_next;
         o_mac_reset       <= recv_next[RECV_SOFT_RST_BIT];
         o_bus_mode        <= bus_mode_next;
         // The event interrupt is a level on status and mask together.
         o_irq             <= |(evt_st_next & evt_msk_next);
      end
   end

endmodule : erp_ctl

/* File: rtl/erp_pkg.sv */
// Functional notes
// [R1] Interrupt output is OR of every status bit whose enable bit is set.
// [R2] Interrupt enable, report and clear go through the function config option register; here enable is OFF_SRC_EN, report OFF_STATUS, clear OFF_SRC_ST.
// [R3] No global interrupt enable exists; only per-source enables gate the interrupt.
// [R4] Hardware reset clears all logic, resamples bus mode, starts EEPROM reload.
// [R5] Soft reset bit resets function except itself, reloads EEPROM, keeps bus mode.
// [R6] While soft reset bit is set, irq/ready line is held low.
// [R7] Clearing the soft reset bit raises the irq/ready line again.
// [R8] MAC soft reset keeps address, config, base; no EEPROM read, no resample.
// [R9] Power-down pin counts only when external codec select is nonzero.
// [R10] Legacy power-down bit powers down transmit, receive and link.
// [R11] Pin: all down plus modem output; wake enable: tx only; legacy_powerdown_bit: tx, rx, link.
// [R12] Pin deassertion wakes without changing any power control or status bit.
// [R13] Power-down bit has precedence over wake enable bit.
// [R14] Host must never write one to the status register power-down bit.
// [R15] Function enable bit has no effect on power state or wake-up.
package erp_pkg;

   ////////////////////////////////////////////////////////////////////////////
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   localparam int SRC_W  = 8;

   localparam logic [3:0] OFF_OPTION  = 4'h0;
   localparam logic [3:0] OFF_STATUS  = 4'h1;
   localparam logic [3:0] OFF_CONTROL = 4'h2;
   localparam logic [3:0] OFF_RECV    = 4'h3;
   localparam logic [3:0] OFF_SRC_ST  = 4'h4;
   localparam logic [3:0] OFF_SRC_EN  = 4'h5;
   localparam logic [3:0] OFF_ADDR    = 4'h6;
   localparam logic [3:0] OFF_CONFIG  = 4'h7;
   localparam logic [3:0] OFF_BASE    = 4'h8;
   localparam logic [3:0] OFF_EVT_ST  = 4'h9;
   localparam logic [3:0] OFF_EVT_MSK = 4'hA;
   localparam logic [3:0] OFF_STATE   = 4'hB;

   localparam int OPT_FUNC_EN_BIT   = 0;
   localparam int OPT_SOFT_RST_BIT  = 7;
   localparam int ST_PDOWN_BIT      = 2;
   localparam int ST_INTR_BIT       = 1;
   localparam int CTL_WAKE_BIT      = 1;
   localparam int CTL_PDOWN_BIT     = 0;
   localparam int RECV_SOFT_RST_BIT = 15;

   localparam logic [15:0] ADDR_RST   = 16'h0000;
   localparam logic [15:0] CONFIG_RST = 16'h0000;
   localparam logic [15:0] BASE_RST   = 16'h0300;

   // Clocks from hard reset release until the synchronised strap is taken.
   localparam logic [1:0] STRAP_WAIT = 2'h3;

   localparam int EVT_W      = 4;
   localparam int EVT_IRQ    = 0;
   localparam int EVT_WAKE   = 1;
   localparam int EVT_PDN    = 2;
   localparam int EVT_RELOAD = 3;

   typedef struct packed {
      logic tx_down;
      logic rx_down;
      logic link_down;
      logic all_down;
   } erp_power_s;

   typedef enum logic [2:0] {
      PS_AWAKE, PS_TX_DOWN, PS_TRL_DOWN, PS_ALL_DOWN
   } erp_pstate_e;

endpackage : erp_pkg
